// >>> src/eeprom_slave.sv
// Dual-mode serial EEPROM: two-wire slave, stream output, protection, APB status
//
// Operation
// [R1] Up to eight data bytes buffered until stop
// [R2] Page write increments only three low bits
// [R3] Overflow wraps within page, overwrites older bytes
// [R4] Stop after write launches programming cycle
// [R5] Master holds stream clock high while writing
// [R6] Programming ignores stream clock once started
// [R7] No acknowledge while programming; polling works
// [R8] Low stream clock blocks all array writes
// [R9] Writing last location sets fuse permanently; the code clears it again on reset
// [R10] Fuse plus low protect pin: read-only
// [R11] Current read returns last address plus one
// [R12] Read control byte: ack then one byte
// [R13] Random read loads pointer before restart
// [R14] Master ack fetches next sequential byte
// [R15] Master changes data only while clock low
// [R16] Falling serial clock leaves stream mode
// [R17] Stream mode drives bit on clock rise
// [R18] Ack only own address and when idle
// [R19] Byte after control loads address pointer
// [R20] Bidirectional mode kept until power loss
// [R21] Programming time is configurable cycle count
// [R22] Refused writes acked but change nothing
// [R23] Seven-bit pointer wraps to zero
`timescale 1ns/1ps
module eeprom_slave #(
    parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES_DEF,
    parameter logic [6:0] DEV_ADDR = 7'h3c // Arbitrary value
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Stream clock and active-low protect pin
    input wire logic stream_clock_in,
    input wire logic wp_n_in
);
    localparam logic [15:0] LEN_RST = 16'(WR_CYCLES);

    if (WR_CYCLES < 1 || WR_CYCLES > 65535) begin : g_bad_len
        $error("WR_CYCLES must lie in 1..65535");
    end

    // Pin synchronisation
    pin_evt_if #(.N(eeprom_pkg::PIN_N)) pin_evt ();
    pin_sync #(.N(eeprom_pkg::PIN_N)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins({wp_n_in, stream_clock_in, sda_in, scl_in}),
        .evt(pin_evt.src)
    );

    wire scl = pin_evt.lvl[eeprom_pkg::PIN_SCL];
    wire sda = pin_evt.lvl[eeprom_pkg::PIN_SDA];
    wire strm = pin_evt.lvl[eeprom_pkg::PIN_STRM];
    wire wp_n = pin_evt.lvl[eeprom_pkg::PIN_WPN];
    wire scl_rise = pin_evt.rise[eeprom_pkg::PIN_SCL];
    wire scl_fall = pin_evt.fall[eeprom_pkg::PIN_SCL];
    wire strm_rise = pin_evt.rise[eeprom_pkg::PIN_STRM];
    // Data edges while the clock is high mark start and stop
    wire bus_start = pin_evt.fall[eeprom_pkg::PIN_SDA] & scl; // [R15]
    wire bus_stop = pin_evt.rise[eeprom_pkg::PIN_SDA] & scl; // [R15]

    eeprom_pkg::mode_t mode_r;
    eeprom_pkg::bus_state_t bs_r;
    logic [7:0] mem_r [eeprom_pkg::ARRAY_BYTES];
    logic [7:0] buf_r [eeprom_pkg::PAGE_BYTES];
    logic [7:0] bvalid_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [1:0] role_r;
    logic rd_r;
    logic [6:0] ptr_r;
    logic [3:0] page_r;
    logic strm_bad_r;
    logic bus_drive_r;
    logic busy_r;
    logic [15:0] prog_cnt_r;
    logic fuse_r;
    logic [15:0] len_r;
    logic [7:0] trans_cnt_r;
    logic [3:0] init_cnt_r;
    logic [6:0] s_addr_r;
    logic [2:0] s_bit_r;
    logic stream_drive_r;

    // Byte boundary decode of the slave
    wire byte_done = (bs_r == eeprom_pkg::BS_RECV) && scl_fall && (bit_cnt_r == 4'h8);
    wire ctl_match = (shift_r[7:1] == DEV_ADDR);
    wire ctl_hit = byte_done && (role_r == 2'd0) && ctl_match && !busy_r; // [R18] [R7]
    wire [7:0] rd_byte = mem_r[ptr_r];
    wire [2:0] low_inc = ptr_r[2:0] + 3'd1;

    // Protection decode
    wire wr_en = strm && (!fuse_r || wp_n); // [R8] [R10]
    wire wr_pending = (role_r == 2'd2) && (bvalid_r != 8'h00) && !busy_r;
    wire launch = bus_stop && (bs_r != eeprom_pkg::BS_IDLE) && wr_pending; // [R4]
    wire commit = launch && wr_en && !strm_bad_r; // [R5] [R22]
    wire [15:0] len_eff = (len_r == 16'h0000) ? 16'h0001 : len_r;

    // Mode switching and transmit-only stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= eeprom_pkg::MD_STREAM;
            trans_cnt_r <= 8'h00;
            init_cnt_r <= 4'h0;
            s_addr_r <= 7'h00;
            s_bit_r <= 3'h7;
            stream_drive_r <= 1'b0;
        end else begin
            case (mode_r)
                eeprom_pkg::MD_STREAM: begin
                    if (scl_fall) begin
                        mode_r <= eeprom_pkg::MD_TRANS; // [R16]
                        trans_cnt_r <= 8'h00;
                        stream_drive_r <= 1'b0;
                    end else if (strm_rise) begin
                        if (init_cnt_r != eeprom_pkg::INIT_EDGES) begin
                            init_cnt_r <= init_cnt_r + 4'h1;
                        end else begin
                            // Open drain: pull low for a zero bit
                            stream_drive_r <= ~mem_r[s_addr_r][s_bit_r]; // [R17]
                            s_bit_r <= s_bit_r - 3'h1;
                            if (s_bit_r == 3'h0) begin
                                s_addr_r <= s_addr_r + 7'h01;
                            end
                        end
                    end
                end
                eeprom_pkg::MD_TRANS: begin
                    if (ctl_hit) begin
                        mode_r <= eeprom_pkg::MD_BIDIR;
                    end else if (scl_fall) begin
                        trans_cnt_r <= 8'h00;
                    end else if (strm_rise && scl) begin
                        trans_cnt_r <= trans_cnt_r + 8'h01;
                        if (trans_cnt_r == eeprom_pkg::REVERT_PULSES - 8'h01) begin
                            mode_r <= eeprom_pkg::MD_STREAM;
                            s_addr_r <= 7'h00;
                            s_bit_r <= 3'h7;
                        end
                    end
                end
                // Only power loss leaves this mode
                eeprom_pkg::MD_BIDIR: mode_r <= eeprom_pkg::MD_BIDIR; // [R20]
                default: mode_r <= eeprom_pkg::MD_STREAM;
            endcase
        end
    end

    // Two-wire slave; start and stop override any bit position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bs_r <= eeprom_pkg::BS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            role_r <= 2'd0;
            rd_r <= 1'b0;
            ptr_r <= 7'h00;
            page_r <= 4'h0;
            bvalid_r <= 8'h00;
            strm_bad_r <= 1'b0;
            bus_drive_r <= 1'b0;
        end else if (mode_r == eeprom_pkg::MD_STREAM) begin
            bs_r <= eeprom_pkg::BS_IDLE;
            bus_drive_r <= 1'b0;
        end else if (bus_start) begin
            // A restart abandons buffered data, the pointer stays
            bs_r <= eeprom_pkg::BS_RECV; // [R13]
            bit_cnt_r <= 4'h0;
            role_r <= 2'd0;
            bvalid_r <= 8'h00;
            strm_bad_r <= ~strm;
            bus_drive_r <= 1'b0;
        end else if (bus_stop) begin
            bs_r <= eeprom_pkg::BS_IDLE;
            bus_drive_r <= 1'b0;
        end else begin
            // Any low stream clock during the transfer spoils the write
            if (!strm) begin
                strm_bad_r <= 1'b1; // [R5]
            end
            case (bs_r)
                eeprom_pkg::BS_RECV: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        bs_r <= eeprom_pkg::BS_ACK;
                        bus_drive_r <= 1'b1;
                        case (role_r)
                            2'd0: begin
                                rd_r <= shift_r[0];
                                if (!ctl_hit) begin
                                    bs_r <= eeprom_pkg::BS_IDLE; // [R18] [R7]
                                    bus_drive_r <= 1'b0;
                                end
                            end
                            2'd1: begin
                                ptr_r <= shift_r[6:0]; // [R19] [R13]
                                page_r <= shift_r[6:3];
                            end
                            default: begin
                                buf_r[ptr_r[2:0]] <= shift_r; // [R1] [R3]
                                bvalid_r[ptr_r[2:0]] <= 1'b1;
                                ptr_r <= {ptr_r[6:3], low_inc}; // [R2]
                            end
                        endcase
                    end
                end
                eeprom_pkg::BS_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rd_r) begin
                            // First bit goes out as the ack clock falls
                            shift_r <= rd_byte; // [R12] [R14] [R11]
                            ptr_r <= ptr_r + 7'h01; // [R23]
                            bus_drive_r <= ~rd_byte[7];
                            bit_cnt_r <= 4'h1;
                            bs_r <= eeprom_pkg::BS_SEND;
                        end else begin
                            bus_drive_r <= 1'b0;
                            bs_r <= eeprom_pkg::BS_RECV;
                            if (role_r != 2'd2) begin
                                role_r <= role_r + 2'd1;
                            end
                        end
                    end
                end
                eeprom_pkg::BS_SEND: begin
                    if (scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        shift_r <= {shift_r[6:0], 1'b0};
                        if (bit_cnt_r == 4'h8) begin
                            bus_drive_r <= 1'b0;
                            bs_r <= eeprom_pkg::BS_RACK;
                        end else begin
                            bus_drive_r <= ~shift_r[6];
                        end
                    end
                end
                eeprom_pkg::BS_RACK: begin
                    // Master ack asks for more; no ack ends the read
                    if (scl_rise) begin
                        bs_r <= sda ? eeprom_pkg::BS_IDLE : eeprom_pkg::BS_ACK; // [R14] [R12]
                    end
                end
                default: bs_r <= eeprom_pkg::BS_IDLE;
            endcase
        end
    end

    // Array cells; all buffered bytes of the page land in one clock at launch
    for (genvar i = 0; i < eeprom_pkg::ARRAY_BYTES; i++) begin : g_cell
        localparam logic [6:0] IDX = 7'(i);
        wire hit = commit && (page_r == IDX[6:3]) && bvalid_r[IDX[2:0]];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_r[i] <= eeprom_pkg::ERASED;
            end else if (hit) begin
                mem_r[i] <= buf_r[IDX[2:0]]; // [R1]
            end
        end
    end

    // Self-timed programming; the stream clock is not looked at here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            prog_cnt_r <= 16'h0000;
        end else if (commit) begin
            busy_r <= 1'b1; // [R4] [R21]
            prog_cnt_r <= len_eff;
        end else if (busy_r) begin
            prog_cnt_r <= prog_cnt_r - 16'h0001; // [R6] [R21]
            if (prog_cnt_r == 16'h0001) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Fuse is set once and cleared only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_r <= 1'b0;
        end else if (commit && page_r == eeprom_pkg::PROT_PAGE
                     && bvalid_r[eeprom_pkg::PROT_ADDR[2:0]]) begin
            fuse_r <= 1'b1; // [R9]
        end
    end

    // Open drain data: output level fixed low, enable pulls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= (mode_r == eeprom_pkg::MD_STREAM) ? stream_drive_r : bus_drive_r;
        end
    end

    // APB decode; one wait state keeps read data registered
    wire apb_acc = psel && penable;
    wire sel_ctrl = (paddr == eeprom_pkg::CTRL_OFS);
    wire sel_stat = (paddr == eeprom_pkg::STATUS_OFS);
    wire apb_wr = apb_acc && pready && pwrite && sel_ctrl;
    wire [31:0] stat_word = {17'h00000, ptr_r, 2'b00, wr_en, fuse_r, busy_r, mode_r};
    wire [31:0] rd_mux = sel_ctrl ? {16'h0000, len_r} : (sel_stat ? stat_word : 32'h00000000);

    // Programming length register steers the busy timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r <= LEN_RST;
        end else if (apb_wr) begin
            len_r <= pwdata[eeprom_pkg::CTRL_LEN_LSB +: eeprom_pkg::CTRL_LEN_W];
        end
    end

    // Answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_acc && !pready;
            pslverr <= apb_acc && !pready && !sel_ctrl && !sel_stat;
            prdata <= (apb_acc && !pready && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule : eeprom_slave

// >>> src/eeprom_pkg.sv
// Shared constants and types of the two-wire serial EEPROM slave
package eeprom_pkg;
    // Array geometry
    localparam int ARRAY_BYTES = 128;
    localparam int PAGE_BYTES = 8;
    localparam logic [6:0] PROT_ADDR = 7'h7f;
    localparam logic [3:0] PROT_PAGE = 4'hf;
    localparam logic [7:0] ERASED = 8'hff;

    // Stream mode timing in link clock edges
    localparam logic [3:0] INIT_EDGES = 4'h9;
    localparam logic [7:0] REVERT_PULSES = 8'h80;

    // Default programming cycle length in pclk cycles
    localparam int WR_CYCLES_DEF = 4000;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;

    // Field positions
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_LEN_W = 16;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_FUSE_BIT = 4;
    localparam int ST_WREN_BIT = 5;
    localparam int ST_PTR_LSB = 8;

    // Pin indices inside the synchroniser vector
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_STRM = 2;
    localparam int PIN_WPN = 3;
    localparam int PIN_N = 4;

    // Operating mode of the device
    typedef enum logic [2:0] {
        MD_STREAM = 3'b001,
        MD_TRANS = 3'b010,
        MD_BIDIR = 3'b100
    } mode_t;

    // Two-wire bus slave states
    typedef enum logic [4:0] {
        BS_IDLE = 5'b00001,
        BS_RECV = 5'b00010,
        BS_ACK = 5'b00100,
        BS_SEND = 5'b01000,
        BS_RACK = 5'b10000
    } bus_state_t;
endpackage : eeprom_pkg

// >>> src/pin_evt_if.sv
// Synchronised pin levels and edge pulses between the pin synchroniser and the slave
`timescale 1ns/1ps
interface pin_evt_if #(parameter int N = 4);
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : pin_evt_if

// >>> src/pin_sync.sv
// Two-flop synchroniser with edge detection for the device pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins
    input wire logic [N-1:0] pins,
    // Synchronised levels and edges
    pin_evt_if.src evt
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] prev_r;

    // Idle bus lines are high, so reset to high avoids false edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '1;
            sync_r <= '1;
            prev_r <= '1;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edges seen only past the second flop
    assign evt.lvl = sync_r;
    assign evt.rise = sync_r & ~prev_r;
    assign evt.fall = ~sync_r & prev_r;
endmodule : pin_sync

// >>> verification/eeprom_slave_chk.sv
// Port-level assertions for the two-wire EEPROM slave
`timescale 1ns/1ps
module eeprom_slave_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic stream_clock_in,
    input wire logic wp_n_in
);
    localparam logic [7:0] CT = eeprom_pkg::CTRL_OFS;
    localparam logic [7:0] SO = eeprom_pkg::STATUS_OFS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] calm_r;
    logic [1:0] pin_q_r;
    logic bidir_r;
    // Status answers, pin settling and the sticky bidirectional mode
    wire logic st_rd = pready && !pwrite && paddr == SO;
    wire logic moved = pin_q_r != {stream_clock_in, wp_n_in};
    wire logic [3:0] calm_nxt = moved ? 4'h0 : calm_r + {3'h0, calm_r != 4'hf};
    wire logic bidir_nxt = bidir_r | (st_rd && prdata[2:0] == 3'b100);
    // Status lags the pins by the synchroniser, so only settled pins are judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calm_r <= 4'h0;
            pin_q_r <= 2'h0;
            bidir_r <= 1'b0;
        end else begin
            calm_r <= calm_nxt;
            pin_q_r <= {stream_clock_in, wp_n_in};
            bidir_r <= bidir_nxt;
        end
    end
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access phase");
    a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("ready not one cycle after access start");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == (paddr != CT && paddr != SO))
        else $error("error flag wrong for address");
    a_rdata_idle: assert property (!pready || pwrite || pslverr |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    a_status_layout: assert property (st_rd |-> prdata[31:15] == 17'h0 && prdata[7:6] == 2'h0
        && $onehot(prdata[2:0])) else $error("status reserved bits or mode wrong");
    a_wren_formula: assert property (st_rd && calm_r > 4'h7 |->
        prdata[5] == (stream_clock_in & (~prdata[4] | wp_n_in)))
        else $error("write enable flag wrong");
    a_bidir_sticky: assert property (bidir_r && st_rd |-> prdata[2:0] == 3'b100)
        else $error("left bidirectional mode");
    a_oe_scl_low: assert property (bidir_r && $changed(sda_oe) |-> !$past(scl_in, 2))
        else $error("data drive changed with clock high");
    c_unmapped: cover property (pready && pslverr);
    c_slave_drives: cover property (bidir_r && $rose(sda_oe));
    c_fuse_read: cover property (st_rd && prdata[4]);
endmodule : eeprom_slave_chk

bind eeprom_slave eeprom_slave_chk eeprom_slave_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .sda_oe(sda_oe), .stream_clock_in(stream_clock_in), .wp_n_in(wp_n_in));

// >>> verification/tw_master.sv
// Behavioural two-wire bus master driving the slave's serial pins
`timescale 1ns/1ps
module tw_master #(
    parameter int H = 8
) (
    // Clock
    input wire logic pclk,
    // Wire level and master drive
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Clock parked high so stream mode is kept
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask : w
    // One bit; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        w(H);
        scl <= 1'b1;
        w(H - 1);
        @(negedge pclk) r = sda;
        @(posedge pclk) scl <= 1'b0;
        w(H);
    endtask : bit_io
    // Start or repeated start: data falls while the clock is high
    task automatic start;
        sda_pull <= 1'b0;
        w(H);
        scl <= 1'b1;
        w(H);
        sda_pull <= 1'b1;
        w(H);
        scl <= 1'b0;
        w(H);
    endtask : start
    task automatic stop;
        sda_pull <= 1'b1;
        w(H);
        scl <= 1'b1;
        w(H);
        sda_pull <= 1'b0;
        w(H);
    endtask : stop
    // MSB first; the slave answers by pulling data low on the ninth clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte
    // A low ninth bit asks for the next address
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(~more, r);
    endtask : rbyte
endmodule : tw_master

// >>> verification/serial_eeprom_slave_access_test.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module serial_eeprom_slave_access_test;
    localparam int WRC = 20;
    localparam logic [6:0] DEV = 7'h3c; // Arbitrary bus address
    localparam logic [7:0] CW = {DEV, 1'b0};
    localparam logic [7:0] CR = {DEV, 1'b1};
    localparam logic [7:0] CT = eeprom_pkg::CTRL_OFS;
    localparam logic [7:0] SO = eeprom_pkg::STATUS_OFS;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sda_out, sda_oe, scl, m_pull, sclk, wp_n, fuse_e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] em [128];
    int err_count, n_compared;
    // Pulled-up data wire
    wire logic sda = ~(sda_oe | m_pull);
    eeprom_slave #(.WR_CYCLES(WRC), .DEV_ADDR(DEV)) eeprom_slave_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .stream_clock_in(sclk), .wp_n_in(wp_n));
    tw_master tw_master_inst (.pclk(pclk), .sda(sda), .scl(scl), .sda_pull(m_pull));
    task automatic tally_and_finish;
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic st(output logic [31:0] s);
        logic e;
        apb(1'b0, SO, 32'h0, s, e);
    endtask : st
    task automatic ctl(input logic [7:0] cb, input logic exp);
        logic k;
        tw_master_inst.start();
        tw_master_inst.wbyte(cb, k);
        `CHK(k, exp)
    endtask : ctl
    task automatic wait_idle;
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            st(s);
            n++;
        end while (s[3] !== 1'b0 && n < 400);
        `CHK(s[3], 1'b0)
    endtask : wait_idle
    // Model follows page wrap and protection; poll also drops the stream clock
    task automatic wr(input logic [6:0] a, input logic [7:0] d0, input int n, input logic poll);
        logic k, ok;
        logic [31:0] s;
        ctl(CW, 1'b1);
        ok = sclk & (~fuse_e | wp_n);
        tw_master_inst.wbyte({1'b0, a}, k);
        `CHK(k, 1'b1)
        for (int i = 0; i < n; i++) begin
            tw_master_inst.wbyte(d0 + 8'(i), k);
            `CHK(k, 1'b1)
            if (ok) em[{a[6:3], 3'(a[2:0] + i)}] = d0 + 8'(i);
        end
        tw_master_inst.stop();
        fuse_e = fuse_e | (ok && a[6:3] == 4'hf && n > 7 - a[2:0]);
        st(s);
        `CHK(s[3], ok)
        if (poll) begin
            sclk <= 1'b0;
            ctl(CW, 1'b0);
            tw_master_inst.stop();
        end
        wait_idle();
    endtask : wr
    task automatic rd_seq(input logic [6:0] a0, input int n);
        logic [7:0] d;
        ctl(CR, 1'b1);
        for (int i = 0; i < n; i++) begin
            tw_master_inst.rbyte(i < n - 1, d);
            `CHK(d, em[7'(a0 + i)])
        end
        tw_master_inst.stop();
    endtask : rd_seq
    task automatic rd_at(input logic [6:0] a, input int n);
        logic k;
        ctl(CW, 1'b1);
        tw_master_inst.wbyte({1'b0, a}, k);
        `CHK(k, 1'b1)
        rd_seq(a, n);
    endtask : rd_at
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        apb(1'b0, CT, 32'h0, r, e);
        `CHK(r, 32'(WRC))
        apb(1'b1, CT, 32'h258, r, e);
        apb(1'b0, CT, 32'h0, r, e);
        `CHK(r, 32'h258)
        apb(1'b1, SO, 32'hffff_ffff, r, e);
        `CHK(e, 1'b0)
        st(r);
        `CHK(r[7:0], 8'h21)
        apb(1'b0, 8'h08, 32'h0, r, e);
        `CHK({e, r}, 33'h1_0000_0000)
    endtask : t_regs
    task automatic t_bad;
        logic [31:0] r;
        ctl(CW ^ 8'h80, 1'b0);
        tw_master_inst.stop();
        st(r);
        `CHK(r[2:0], 3'b010)
        ctl(CR ^ 8'h02, 1'b0);
        tw_master_inst.stop();
    endtask : t_bad
    task automatic t_poll;
        logic [31:0] r;
        wr(7'h10, 8'ha5, 1, 1'b1);
        sclk <= 1'b1;
        st(r);
        `CHK(r[2:0], 3'b100)
        rd_at(7'h10, 1);
        rd_seq(7'h11, 1);
    endtask : t_poll
    task automatic t_page;
        wr(7'h00, 8'h11, 1, 1'b0);
        wr(7'h25, 8'h40, 10, 1'b0);
        rd_at(7'h20, 9);
        rd_at(7'h7e, 3);
    endtask : t_page
    task automatic t_protect;
        logic [31:0] r;
        sclk <= 1'b0;
        wr(7'h30, 8'h5a, 1, 1'b0);
        sclk <= 1'b1;
        wr(7'h7f, 8'h99, 1, 1'b0);
        wp_n <= 1'b0;
        wr(7'h40, 8'h12, 1, 1'b0);
        st(r);
        `CHK(r[5:4], 2'b01)
        wp_n <= 1'b1;
        wr(7'h41, 8'h34, 1, 1'b0);
        rd_at(7'h3f, 3);
        rd_at(7'h30, 1);
    endtask : t_protect
    task automatic t_stream;
        repeat (24) begin
            repeat (4) @(posedge pclk);
            sclk <= ~sclk;
        end
        `CHK({sda, sda_out}, 2'b10)
    endtask : t_stream
    // Free-running clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Reset, then the scenarios in turn
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        sclk = 1'b1;
        wp_n = 1'b1;
        fuse_e = 1'b0;
        foreach (em[i]) em[i] = eeprom_pkg::ERASED;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_stream();
        t_regs();
        t_bad();
        t_poll();
        t_page();
        t_protect();
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end
endmodule : serial_eeprom_slave_access_test
